// ===== hw/jlt_pkg.sv
package jlt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [11:0] REG_LINK_CTRL = 12'h571;
  localparam logic [11:0] REG_SYNC_CTRL = 12'h572;
  localparam logic [11:0] REG_PATTERN = 12'h573;
  localparam logic [11:0] REG_ILAS_LTM = 12'h574;
  localparam logic [11:0] REG_LMFC_OFS = 12'h578;
  localparam logic [11:0] REG_STATUS = 12'h579;
  localparam logic [7:0] RESET_VALUE = 8'h00;

  // field positions
  localparam int LINK_OFF_BIT = 0;
  localparam int SYNC_INV_BIT = 5;
  localparam int SYNC_CTL_LSB = 6;
  localparam int ILAS_DLY_LSB = 4;
  localparam int LTM_LSB = 0;
  localparam int PAT_LSB = 0;
  localparam int LMFC_OFS_LSB = 0;

  // sync input control
  localparam logic [1:0] SYNC_FORCE_CGS = 2'h2;
  localparam logic [1:0] SYNC_FORCE_ILAS = 2'h3;

  // sample test patterns
  localparam logic [3:0] PAT_NORMAL = 4'h0;
  localparam logic [3:0] PAT_CHECKER = 4'h1;
  localparam logic [3:0] PAT_TOGGLE = 4'h2;
  localparam logic [3:0] PAT_PN31 = 4'h3;
  localparam logic [3:0] PAT_PN23 = 4'h4;
  localparam logic [3:0] PAT_PN15 = 4'h5;
  localparam logic [3:0] PAT_PN9 = 4'h6;
  localparam logic [3:0] PAT_PN7 = 4'h7;
  localparam logic [3:0] PAT_RAMP = 4'h8;
  localparam logic [15:0] CHECKER_A = 16'h5555;
  localparam logic [15:0] CHECKER_B = 16'hAAAA;
  localparam logic [15:0] TOGGLE_ONES = 16'hFFFF;
  localparam logic [15:0] TOGGLE_ZEROS = 16'h0000;
  localparam logic [30:0] PN_SEED = 31'h7FFFFFFF;

  // link layer test modes
  localparam logic [2:0] LTM_NORMAL = 3'h0;
  localparam logic [2:0] LTM_D215 = 3'h1;
  localparam logic [2:0] LTM_RPAT = 3'h4;
  localparam logic [2:0] LTM_JSPAT = 3'h5;
  localparam logic [2:0] LTM_JTSPAT = 3'h6;

  // control characters and data characters
  localparam logic [7:0] CHAR_K285 = 8'hBC;
  localparam logic [7:0] CHAR_R = 8'h1C;
  localparam logic [7:0] CHAR_A = 8'h7C;
  localparam logic [7:0] CHAR_Q = 8'h9C;
  localparam logic [7:0] CHAR_D215 = 8'hB5;

  // test sequence tables, 24 octets each, octet 0 in the low byte
  localparam logic [4:0] SEQ_LAST = 5'h16;
  localparam logic [191:0] SEQ_RPAT =
    192'h355EFB14B38F6B472323D7BE59355EFB14B38F6B4723D7BE;
  localparam logic [191:0] SEQ_JSPAT =
    192'h38972FFE80D57E7E7F38972FFE80D57E7E7F38972FFE80D5;
  localparam logic [191:0] SEQ_JTSPAT =
    192'h80D57E7EBCBCBC7F38972FFE80D57E7E7F38972FFE80D57E;

  // multiframe timing
  localparam logic [4:0] LMFC_LAST = 5'h1F;
  localparam logic [6:0] ILAS_LAST = 7'h7F;
  localparam logic [1:0] ILAS_Q_FRAME = 2'h1;

  // fifo shape
  localparam int FIFO_DEPTH = 32;
  localparam int SAMPLE_W = 16;

  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_CGS = 5'h02,
    ST_WAIT = 5'h04,
    ST_ILAS = 5'h08,
    ST_DATA = 5'h10
  } jlt_state_t;

  typedef struct packed {
    logic [15:0] data;
    logic [1:0] k;
  } jlt_lane_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } jlt_reg_req_t;

endpackage

// ===== hw/jlt_fifo.sv
`timescale 1ns/1ps
module jlt_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid & in_ready;
  wire load = (count != '0) & (~out_valid | out_ready);
  wire [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};

  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
    if (load)
    begin
      out_data <= mem[rd_ptr];
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(load);
      count <= next_count;
      in_ready <= next_count != FULL;
      out_valid <= load | (out_valid & ~out_ready);
    end
  end
endmodule // jlt_fifo

// ===== hw/jlt_link_ctrl.sv
`timescale 1ns/1ps
module jlt_link_ctrl (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // register port
  input wire jlt_pkg::jlt_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // converter samples
  input wire logic [15:0] sample_data,
  input wire logic sample_valid,
  output logic sample_ready,
  // link timing and sync
  input wire logic sysref,
  input wire logic sync_request_input_b,
  // lane output
  output jlt_pkg::jlt_lane_t lane,
  output logic lane_valid
);
  import jlt_pkg::*;

  function automatic logic [30:0] pn_advance(logic [3:0] sel, logic [30:0] s);
    int len;
    int tap;
    logic [30:0] r;
    logic fb;
    r = s;
    case (sel)
      PAT_PN31: begin len = 31; tap = 28; end
      PAT_PN23: begin len = 23; tap = 18; end
      PAT_PN15: begin len = 15; tap = 14; end
      PAT_PN9: begin len = 9; tap = 5; end
      default: begin len = 7; tap = 6; end
    endcase
    for (int i = 0; i < 16; i++)
    begin
      fb = r[len-1] ^ r[tap-1];
      r = {r[29:0], fb};
    end
    return r;
  endfunction

  function automatic logic [7:0] seq_octet(logic [2:0] mode, logic [4:0] idx);
    logic [191:0] tbl;
    tbl = (mode == LTM_RPAT) ? SEQ_RPAT : (mode == LTM_JSPAT) ? SEQ_JSPAT : SEQ_JTSPAT;
    return tbl[int'(idx)*8 +: 8];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic link_off;
  logic [1:0] sync_ctl;
  logic sync_inv;
  logic [7:0] pattern_reg;
  logic [3:0] ilas_delay;
  logic [2:0] ltm;
  logic [4:0] lmfc_phase_offset;
  jlt_state_t state;

  wire wr_link = reg_req.wr & (reg_req.addr == REG_LINK_CTRL);
  wire wr_sync = reg_req.wr & (reg_req.addr == REG_SYNC_CTRL);
  wire wr_pat = reg_req.wr & (reg_req.addr == REG_PATTERN);
  wire wr_ilas = reg_req.wr & (reg_req.addr == REG_ILAS_LTM);
  wire wr_ofs = reg_req.wr & (reg_req.addr == REG_LMFC_OFS);
  wire [3:0] pattern_sel = pattern_reg[PAT_LSB +: 4];

  logic [7:0] next_rdata;
  always_comb
  begin
    case (reg_req.addr)
      REG_LINK_CTRL: next_rdata = {7'h00, link_off};
      REG_SYNC_CTRL: next_rdata = {sync_ctl, sync_inv, 5'h00};
      REG_PATTERN: next_rdata = pattern_reg;
      REG_ILAS_LTM: next_rdata = {ilas_delay, 1'b0, ltm};
      REG_LMFC_OFS: next_rdata = {3'h0, lmfc_phase_offset};
      REG_STATUS: next_rdata = {3'h0, state};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      link_off <= 1'b0;
      sync_ctl <= 2'h0;
      sync_inv <= 1'b0;
      pattern_reg <= RESET_VALUE;
      ilas_delay <= 4'h0;
      ltm <= LTM_NORMAL;
      lmfc_phase_offset <= 5'h00;
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      if (wr_link) link_off <= reg_req.wdata[LINK_OFF_BIT];
      if (wr_sync) sync_ctl <= reg_req.wdata[SYNC_CTL_LSB +: 2];
      if (wr_sync) sync_inv <= reg_req.wdata[SYNC_INV_BIT];
      if (wr_pat) pattern_reg <= reg_req.wdata;
      if (wr_ilas) ilas_delay <= reg_req.wdata[ILAS_DLY_LSB +: 4];
      if (wr_ilas) ltm <= reg_req.wdata[LTM_LSB +: 3];
      if (wr_ofs) lmfc_phase_offset <= reg_req.wdata[LMFC_OFS_LSB +: 5];
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) reg_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // test pattern generator and sample fifo
  logic pg_phase;
  logic [15:0] pg_ramp;
  logic [30:0] pg_lfsr;
  logic [15:0] pat_word;
  wire push = sample_valid & sample_ready;

  always_comb
  begin
    case (pattern_sel)
      PAT_CHECKER: pat_word = pg_phase ? CHECKER_B : CHECKER_A;
      PAT_TOGGLE: pat_word = pg_phase ? TOGGLE_ZEROS : TOGGLE_ONES;
      PAT_PN31, PAT_PN23, PAT_PN15, PAT_PN9, PAT_PN7: pat_word = pg_lfsr[15:0];
      PAT_RAMP: pat_word = pg_ramp;
      default: pat_word = sample_data;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pg_phase <= 1'b0;
      pg_ramp <= 16'h0000;
      pg_lfsr <= PN_SEED;
    end
    else if (wr_pat)
    begin
      pg_phase <= 1'b0;
      pg_ramp <= 16'h0000;
      pg_lfsr <= PN_SEED;
    end
    else if (push)
    begin
      pg_phase <= ~pg_phase;
      pg_ramp <= pg_ramp + 16'h0001;
      pg_lfsr <= pn_advance(pattern_sel, pg_lfsr);
    end
  end

  logic fifo_out_valid;
  logic [15:0] fifo_out_data;
  wire ltm_normal = (ltm != LTM_D215) & (ltm != LTM_RPAT) & (ltm != LTM_JSPAT)
                    & (ltm != LTM_JTSPAT);
  wire fifo_drain = ~link_off & ltm_normal & (state == ST_DATA);

  // pattern words enter the same path as samples, so framing is untouched
  jlt_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst_b(rst_b),
    .in_valid(sample_valid),
    .in_data(pat_word),
    .in_ready(sample_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(fifo_drain)
  );

  ////////////////////////////////////////////////////////////////////////////
  // lmfc phase counter
  logic [4:0] lmfc_count;
  wire [4:0] next_lmfc = sysref ? lmfc_phase_offset :
                         (lmfc_count == LMFC_LAST) ? 5'h00 : lmfc_count + 5'h01;
  wire boundary_next = next_lmfc == 5'h00;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b) lmfc_count <= 5'h00;
    else lmfc_count <= next_lmfc;
  end

  ////////////////////////////////////////////////////////////////////////////
  // link state machine
  wire sync_req = ~sync_request_input_b ^ sync_inv;
  wire eff_req = (sync_ctl == SYNC_FORCE_CGS) ? 1'b1 :
                 (sync_ctl == SYNC_FORCE_ILAS) ? 1'b0 : sync_req;
  logic [3:0] seen;
  logic [6:0] ilas_cnt;
  jlt_state_t next_state;

  always_comb
  begin
    next_state = state;
    case (state)
      ST_OFF: next_state = ST_CGS;
      ST_CGS: if (!eff_req) next_state = ST_WAIT;
      ST_WAIT:
        if (eff_req) next_state = ST_CGS;
        else if (boundary_next && seen == ilas_delay) next_state = ST_ILAS;
      ST_ILAS:
        if (eff_req) next_state = ST_CGS;
        else if (ilas_cnt == ILAS_LAST) next_state = ST_DATA;
      ST_DATA: if (eff_req) next_state = ST_CGS;
      default: next_state = ST_OFF;
    endcase
    if (link_off) next_state = ST_OFF;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= ST_OFF;
      seen <= 4'h0;
      ilas_cnt <= 7'h00;
    end
    else
    begin
      state <= next_state;
      seen <= (state == ST_WAIT) ? seen + 4'(boundary_next) : 4'h0;
      ilas_cnt <= (state == ST_ILAS) ? ilas_cnt + 7'h01 : 7'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lane word
  logic [4:0] seq_idx;
  jlt_lane_t ilas_word;
  jlt_lane_t next_lane;
  logic next_valid;
  wire seq_mode = (ltm == LTM_RPAT) | (ltm == LTM_JSPAT) | (ltm == LTM_JTSPAT);
  wire ilas_first = ilas_cnt[4:0] == 5'h00;
  wire ilas_last = ilas_cnt[4:0] == LMFC_LAST;

  // ilas words: R opens each multiframe, Q marks the second, A closes each
  wire ilas_q_here = ilas_first && (ilas_cnt[6:5] == ILAS_Q_FRAME);
  wire [7:0] ilas_lo = ilas_first ? CHAR_R : {ilas_cnt, 1'b0};
  wire [7:0] ilas_hi = ilas_q_here ? CHAR_Q : ilas_last ? CHAR_A : {ilas_cnt, 1'b1};
  assign ilas_word = {ilas_hi, ilas_lo, ilas_q_here || ilas_last, ilas_first};

  always_comb
  begin
    next_lane = '0;
    next_valid = 1'b1;
    if (link_off)
    begin
      next_valid = 1'b0;
    end
    else if (ltm == LTM_D215)
    begin
      next_lane.data = {CHAR_D215, CHAR_D215};
    end
    else if (seq_mode)
    begin
      next_lane.data = {seq_octet(ltm, seq_idx + 5'h01), seq_octet(ltm, seq_idx)};
    end
    else
    begin
      case (state)
        ST_ILAS: next_lane = ilas_word;
        ST_DATA:
        begin
          next_lane.data = fifo_out_data;
          next_valid = fifo_out_valid;
        end
        default:
        begin
          next_lane.data = {CHAR_K285, CHAR_K285};
          next_lane.k = 2'h3;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lane <= '0;
      lane_valid <= 1'b0;
      seq_idx <= 5'h00;
    end
    else
    begin
      lane <= next_lane;
      lane_valid <= next_valid;
      seq_idx <= (!seq_mode || seq_idx == SEQ_LAST) ? 5'h00 : seq_idx + 5'h02;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_wait_ready;
    state == ST_WAIT && !eff_req && !link_off && boundary_next && seen == ilas_delay;
  endsequence
  sequence s_ilas_begin;
    state == ST_ILAS && ilas_cnt == 7'h00;
  endsequence

  a_ilas_boundary_start: assert property (s_wait_ready |=> s_ilas_begin and lmfc_count == 5'h00)
    else $error("ilas did not start on the chosen lmfc boundary");
  a_ilas_delay_count: assert property ($rose(state == ST_ILAS) |-> $past(seen) == $past(ilas_delay))
    else $error("ilas started after the wrong number of boundaries");
  a_sysref_phase_load: assert property (sysref |=> lmfc_count == $past(lmfc_phase_offset))
    else $error("lmfc counter not loaded with offset on sysref");
  a_cgs_k_chars: assert property (state == ST_CGS && !link_off && ltm_normal |=>
    lane.data == {CHAR_K285, CHAR_K285} && lane.k == 2'h3 && lane_valid)
    else $error("cgs state did not send k28.5");
  a_d215_stream: assert property ((ltm == LTM_D215 && !link_off) [*2] |=>
    lane.data == {CHAR_D215, CHAR_D215} && lane.k == 2'h0 && lane_valid)
    else $error("d21.5 stream broken");
  a_force_cgs_hold: assert property (sync_ctl == SYNC_FORCE_CGS && !link_off &&
    state != ST_OFF |=> state == ST_CGS)
    else $error("forced cgs not honoured");
  a_force_ilas_go: assert property (sync_ctl == SYNC_FORCE_ILAS && state == ST_CGS &&
    !link_off |=> state == ST_WAIT ##[1:544] state == ST_ILAS)
    else $error("forced ilas did not ignore the sync request");
  a_ramp_step: assert property (push && pattern_sel == PAT_RAMP && !wr_pat |=>
    pat_word == $past(pat_word) + 16'h0001)
    else $error("ramp did not step by one");
  a_normal_passthru: assert property (pattern_sel == PAT_NORMAL |-> pat_word == sample_data)
    else $error("normal pattern does not pass samples");
  a_reserved_ltm: assert property ((ltm == 3'h2 || ltm == 3'h3 || ltm == 3'h7) &&
    !link_off && state == ST_DATA |=> lane.k == 2'h0)
    else $error("reserved link test code altered the lane");
endmodule // jlt_link_ctrl

// ===== verif/jlt_rx_model.sv
`timescale 1ns/1ps
module jlt_rx_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // lane from the transmitter
  input wire jlt_pkg::jlt_lane_t lane,
  input wire logic lane_valid,
  // bench control: low holds the sync request
  input wire logic go,
  // sync request back to the transmitter
  output logic sync_request_input_b
);
  import jlt_pkg::*;
  logic [2:0] k_run;
  wire logic comma = lane_valid && lane.k == 2'h3 && lane.data == {CHAR_K285, CHAR_K285};
  // release only after four comma words since go rose, as a real receiver would
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      k_run <= 3'h0;
      sync_request_input_b <= 1'b0;
    end
    else if (!go)
    begin
      k_run <= 3'h0;
      sync_request_input_b <= 1'b0;
    end
    else if (comma)
    begin
      k_run <= k_run + 3'h1;
      if (k_run == 3'h3)
        sync_request_input_b <= 1'b1;
    end
  end
endmodule // jlt_rx_model

// ===== verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import jlt_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  jlt_reg_req_t reg_req = '0;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic [15:0] sample_data = 16'h0000;
  logic sample_valid = 1'b0;
  logic sample_ready;
  logic sysref = 1'b0;
  logic sync_request_input_b;
  jlt_lane_t lane;
  logic lane_valid;
  logic go = 1'b0;
  logic took;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  int t0;
  logic [15:0] w [0:11];

  always #2.5 clock = ~clock;

  jlt_link_ctrl dut (.clock(clock), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .sample_data(sample_data), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sysref(sysref), .sync_request_input_b(sync_request_input_b),
    .lane(lane), .lane_valid(lane_valid));
  jlt_rx_model rx (.clock(clock), .rst_b(rst_b), .lane(lane), .lane_valid(lane_valid),
    .go(go), .sync_request_input_b(sync_request_input_b));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end

  // samples step by 3 so that pass-through and ramp differ
  always @(posedge clock)
  begin
    took = sample_valid & sample_ready;
    #1;
    if (took === 1'b1)
      sample_data = sample_data + 16'h0003;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    tick(1);
    reg_req = '0;
    tick(1);
  endtask

  task automatic reg_chk(input logic [11:0] a, input logic [7:0] e);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    tick(1);
    reg_req = '0;
    check({15'h0, reg_rvalid}, 16'h0001, "read valid");
    check({8'h00, reg_rdata}, {8'h00, e}, "register read");
    tick(1);
  endtask

  // capture n valid lane words
  task automatic grab(input int n);
    int i;
    int lim;
    i = 0;
    lim = 0;
    while (i < n && lim < 100)
    begin
      if (lane_valid === 1'b1)
      begin
        w[i] = lane.data;
        i++;
      end
      tick(1);
      lim++;
    end
    check(i[15:0], n[15:0], "lane words");
  endtask

  function automatic logic [15:0] seq(input logic [2:0] c, input int j);
    if (c == LTM_RPAT)
      return SEQ_RPAT[j*16 +: 16];
    if (c == LTM_JSPAT)
      return SEQ_JSPAT[j*16 +: 16];
    return SEQ_JTSPAT[j*16 +: 16];
  endfunction

  // x holds three pattern words, newest bit at 0; every new bit must obey the taps
  function automatic logic pn_ok(input int c, input logic [47:0] x);
    int len;
    int tap;
    logic good;
    len = (c == 3) ? 31 : (c == 4) ? 23 : (c == 5) ? 15 : (c == 6) ? 9 : 7;
    tap = (c == 3) ? 28 : (c == 4) ? 18 : (c == 5) ? 14 : (c == 6) ? 5 : 6;
    good = 1'b1;
    for (int p = 0; p < 16; p++)
      if (x[p] !== (x[p + len] ^ x[p + tap]))
        good = 1'b0;
    return good;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    reg_chk(REG_PATTERN, 8'h00);
    reg_chk(REG_ILAS_LTM, 8'h00);
    reg_chk(REG_LMFC_OFS, 8'h00);
    reg_wr(12'h600, 8'hFF);
    reg_chk(12'h600, 8'h00);
    reg_wr(REG_ILAS_LTM, 8'hFF);
    reg_chk(REG_ILAS_LTM, 8'hF7);
    reg_wr(REG_LMFC_OFS, 8'hFF);
    reg_chk(REG_LMFC_OFS, 8'h1F);
    reg_wr(REG_ILAS_LTM, 8'h00);
  endtask

  // far side holds sync, so the fifo fills until it refuses
  task automatic t_fill;
    check(lane.data, {CHAR_K285, CHAR_K285}, "comma word");
    check({14'h0, lane.k}, 16'h0003, "comma k");
    sample_valid = 1'b1;
    tick(60);
    check({15'h0, sample_ready}, 16'h0000, "fifo full");
  endtask

  task automatic ilas_at(input logic [4:0] ofs, input logic [3:0] n, output int t);
    reg_wr(REG_LMFC_OFS, {3'h0, ofs});
    reg_wr(REG_ILAS_LTM, {n, 4'h0});
    go = 1'b0;
    tick(8);
    sysref = 1'b1;
    tick(1);
    sysref = 1'b0;
    go = 1'b1;
    t = 0;
    while (!(lane.k[0] === 1'b1 && lane.data[7:0] === CHAR_R) && t < 700)
    begin
      tick(1);
      t++;
    end
  endtask

  task automatic t_ilas;
    int t;
    ilas_at(5'h00, 4'h0, t0);
    ilas_at(5'h04, 4'h0, t);
    check(t[15:0], t0[15:0] - 16'h0004, "offset shift");
    ilas_at(5'h00, 4'h2, t);
    check(t[15:0], t0[15:0] + 16'h0040, "delay two");
    ilas_at(5'h00, 4'hF, t);
    check(t[15:0], t0[15:0] + 16'h01E0, "delay fifteen");
    tick(5);
    reg_chk(REG_STATUS, 8'h08);
    tick(140);
    reg_chk(REG_STATUS, 8'h10);
  endtask

  task automatic t_patterns;
    logic ok;
    for (int c = 0; c < 9; c++)
    begin
      reg_wr(REG_PATTERN, c[7:0]);
      tick(60);
      grab(8);
      for (int i = 0; i < 7; i++)
      begin
        ok = w[i + 1] !== w[i] && w[i + 1] !== w[i] + 16'h0003;
        if (c == 0)
          check(w[i + 1], w[i] + 16'h0003, "pass-through");
        else if (c == 8)
          check(w[i + 1], w[i] + 16'h0001, "ramp");
        else if (c == 1)
          check({15'h0, w[i] === CHECKER_A && w[i + 1] === CHECKER_B
            || w[i] === CHECKER_B && w[i + 1] === CHECKER_A}, 16'h0001, "checker");
        else if (c == 2)
          check({15'h0, w[i] === TOGGLE_ONES && w[i + 1] === TOGGLE_ZEROS
            || w[i] === TOGGLE_ZEROS && w[i + 1] === TOGGLE_ONES}, 16'h0001, "toggle");
        else
        begin
          check({15'h0, ok}, 16'h0001, "pn word");
          if (i < 6)
            check({15'h0, pn_ok(c, {w[i], w[i + 1], w[i + 2]})}, 16'h0001, "pn taps");
        end
      end
    end
    reg_wr(REG_PATTERN, 8'h00);
    sample_valid = 1'b0;
    tick(50);
    check({15'h0, lane_valid}, 16'h0000, "fifo drained");
    sample_valid = 1'b1;
  endtask

  task automatic t_ltm;
    logic [2:0] list [0:6];
    logic [2:0] c;
    int hit;
    logic whole;
    list = '{3'h1, 3'h4, 3'h5, 3'h6, 3'h2, 3'h3, 3'h7};
    for (int k = 0; k < 7; k++)
    begin
      c = list[k];
      reg_wr(REG_ILAS_LTM, {5'h00, c});
      tick(4);
      grab(12);
      // a word can occur twice in a table, so the phase is found from all twelve
      hit = -1;
      for (int j = 0; j < 12; j++)
      begin
        whole = 1'b1;
        for (int i = 0; i < 12; i++)
          if (seq(c, (j + i) % 12) !== w[i])
            whole = 1'b0;
        if (whole)
          hit = j;
      end
      for (int i = 0; i < 12; i++)
        if (c == LTM_D215)
          check(w[i], {CHAR_D215, CHAR_D215}, "d21.5 stream");
        else if (c >= LTM_RPAT && c <= LTM_JTSPAT)
          check(w[i], seq(c, (hit + i) % 12), "test sequence");
        else
          check({15'h0, w[i] === {CHAR_D215, CHAR_D215}}, 16'h0000, "reserved");
    end
    reg_wr(REG_ILAS_LTM, 8'h00);
  endtask

  task automatic t_sync;
    reg_wr(REG_SYNC_CTRL, 8'h80);
    tick(4);
    check(lane.data, {CHAR_K285, CHAR_K285}, "forced comma");
    reg_wr(REG_SYNC_CTRL, 8'hC0);
    go = 1'b0;
    tick(300);
    reg_chk(REG_STATUS, 8'h10);
    reg_wr(REG_SYNC_CTRL, 8'h00);
    tick(4);
    reg_chk(REG_STATUS, 8'h02);
    check(lane.data, {CHAR_K285, CHAR_K285}, "comma again");
  endtask

  initial
  begin
    tick(8);
    rst_b = 1'b1;
    tick(2);
    t_regs();
    t_fill();
    t_ilas();
    t_patterns();
    t_ltm();
    t_sync();
    tally_and_finish();
  end
endmodule // testbench
